// file: common/rng_pkg.sv
// Constants, types and defaults shared by the hybrid random generator and its checker and testbench.
// Assumes one clock domain and a consumer that drains words through a valid/ready pair.
//
// Operation
// R1 - Right after a start the raw source is checked for total failure, and nothing is released once one is seen.
// R2 - A total failure during operation withholds every word that used raw bits arriving after the failure began.
// R3 - An online statistical test runs on the raw bits at start-up and during operation and flags defects.
// R4 - Output stays blocked until the start-up test passes and the post-processor is seeded, and blocks again on a defect.
// R5 - Every raw bit is examined by the online test as it arrives, with no request needed; the code examines raw bits only in ST_STARTUP and ST_RUN.
// R6 - The post-processor never emits more output bits than it has taken compressed input bits.
// R7 - The post-processor uses one state transition function and a separate output function.
// R8 - Delivered words are either 8 or 16 bits wide.
// R9 - Raw bits are compressed adaptively, at a ratio chosen by an entropy estimator.
// R10 - The post-processor holds a 351-bit state seeded from the physical entropy source.
// R11 - A total failure or statistical defect sets a sticky error output held until the next start.
// R12 - A valid flag comes with each word and is high only while release is permitted.
package rng_pkg;
   localparam int STATE_BITS  = 351;  // Post-processor state length
   localparam int SEED_BITS   = 351;  // Compressed bits absorbed before first release
   localparam int WORD_W      = 16;
   localparam int NARROW_W    = 8;
   localparam int RUN_LIMIT   = 32;   // Identical raw bits in a row meaning total failure
   localparam int WIN_LEN     = 256;  // Online test window in raw bits
   localparam int ONES_LO     = 96;   // Tolerated ones per window, low bound
   localparam int ONES_HI     = 160;  // Tolerated ones per window, high bound
   localparam int TIGHT_LO    = 112;  // Estimator band allowing fine compression
   localparam int TIGHT_HI    = 144;
   localparam int COMP_FINE   = 2;    // Raw bits per compressed bit, good entropy
   localparam int COMP_COARSE = 4;    // Raw bits per compressed bit, weaker entropy
   localparam int FIFO_DEPTH  = 8;
   localparam int CREDIT_W    = 6;
   // Tap positions of the transition and output functions
   localparam int TAP_FB = 350;
   localparam int TAP_A  = 287;
   localparam int TAP_B  = 193;
   localparam int TAP_C  = 101;
   localparam int TAP_D  = 57;
   localparam int TAP_E  = 13;
   localparam int OUT_A  = 340;
   localparam int OUT_B  = 222;
   localparam int OUT_C  = 150;
   localparam int OUT_D  = 77;
   localparam int OUT_E  = 5;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_STARTUP,
      ST_RUN,
      ST_FAIL
   } gen_state_e;
endpackage

// file: hdl/rng_fifo.sv
// Word FIFO with a registered read stage and a flush.
// Assumes writer and reader share i_mclk; DEPTH must be a power of two.
`timescale 1ns/1ns
`default_nettype none
module rng_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire  logic             i_mclk,
   input  wire  logic             i_resetn,
   input  wire  logic             i_flush,
   input  wire  logic             i_wr_valid,
   output logic                   o_wr_ready,
   input  wire  logic [WIDTH-1:0] i_wr_data,
   output logic                   o_rd_valid,
   input  wire  logic             i_rd_ready,
   output logic       [WIDTH-1:0] o_rd_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
         $error("rng_fifo: DEPTH must be a power of two of at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr_reg, wr_ptr_next;
   logic [PW-1:0]    rd_ptr_reg, rd_ptr_next;
   logic [CW-1:0]    count_reg, count_next;
   logic             valid_reg, valid_next;
   logic [WIDTH-1:0] data_reg, data_next;
   logic             push;
   logic             load;

   // Ready drops at DEPTH words
   assign o_wr_ready = (count_reg != FULL_CNT);
   assign o_rd_valid = valid_reg;
   assign o_rd_data  = data_reg;

   // Pointer, count and output stage next values
   always_comb begin
      push        = i_wr_valid && o_wr_ready;
      load        = (!valid_reg || i_rd_ready) && (count_reg != '0);
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      count_next  = count_reg;
      valid_next  = valid_reg;
      data_next   = data_reg;
      if (push) begin
         wr_ptr_next = wr_ptr_reg + 1'b1;
      end
      if (load) begin
         rd_ptr_next = rd_ptr_reg + 1'b1;
         data_next   = mem[rd_ptr_reg];
         valid_next  = 1'b1;
      end else if (i_rd_ready) begin
         valid_next  = 1'b0;
      end
      count_next = count_reg + CW'(push) - CW'(load);
      // Flush also drops a word being written
      if (i_flush) begin
         wr_ptr_next = '0;
         rd_ptr_next = '0;
         count_next  = '0;
         valid_next  = 1'b0;
      end
   end

   // Storage array, no reset needed on data
   always_ff @(posedge i_mclk) begin
      if (push && !i_flush) begin
         mem[wr_ptr_reg] <= i_wr_data;
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
         valid_reg  <= 1'b0;
         data_reg   <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg  <= count_next;
         valid_reg  <= valid_next;
         data_reg   <= data_next;
      end
   end
endmodule // rng_fifo
`default_nettype wire

// file: hdl/hybrid_rng_health_gate.sv
// Hybrid generator: health tests on raw bits, adaptive compression, post-processor, gated word FIFO.
// Assumes raw bits arrive synchronous to i_mclk, at most one per cycle, flagged by i_raw_valid.
`timescale 1ns/1ns
`default_nettype none
module hybrid_rng_health_gate
   import rng_pkg::*;
#(
   parameter int RUN_MAX_P  = RUN_LIMIT,
   parameter int WIN_P      = WIN_LEN,
   parameter int LO_P       = ONES_LO,
   parameter int HI_P       = ONES_HI,
   parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
   input  wire  logic              i_mclk,
   input  wire  logic              i_resetn,
   input  wire  logic              i_start,
   input  wire  logic              i_raw_valid,
   input  wire  logic              i_raw_bit,
   input  wire  logic              i_word16,
   input  wire  logic              i_rd_ready,
   output logic       [WORD_W-1:0] o_rd_data,
   output logic                    o_rd_valid,
   output logic                    o_total_fail,
   output logic                    o_stat_defect,
   output logic                    o_released,
   output logic                    o_seeded
);
   localparam int RW = $clog2(RUN_MAX_P + 1);
   localparam int WW = $clog2(WIN_P);
   localparam int OW = $clog2(WIN_P + 1);
   localparam int SW = $clog2(SEED_BITS + 1);
   localparam logic [RW-1:0] RUN_TOP  = RW'(RUN_MAX_P);
   localparam logic [WW-1:0] WIN_LAST = WW'(WIN_P - 1);
   localparam logic [OW-1:0] LO_C     = OW'(LO_P);
   localparam logic [OW-1:0] HI_C     = OW'(HI_P);
   localparam logic [OW-1:0] TLO_C    = OW'(TIGHT_LO);
   localparam logic [OW-1:0] THI_C    = OW'(TIGHT_HI);
   localparam logic [SW-1:0] SEED_LAST = SW'(SEED_BITS - 1);
   localparam logic [2:0]    FINE_LAST   = 3'(COMP_FINE - 1);
   localparam logic [2:0]    COARSE_LAST = 3'(COMP_COARSE - 1);
   localparam logic [4:0]    W16_LAST = 5'(WORD_W - 1);
   localparam logic [4:0]    W8_LAST  = 5'(NARROW_W - 1);
   localparam logic [CREDIT_W-1:0] CREDIT_TOP = '1;

   generate
      if (RUN_MAX_P < 2 || WIN_P < 2 || LO_P >= HI_P || HI_P > WIN_P) begin : g_bad
         $error("hybrid_rng_health_gate: test thresholds out of range");
      end
   endgenerate

   // Transition function: nonlinear feedback shift with input absorbed
   function automatic logic [STATE_BITS-1:0] pp_step(input logic [STATE_BITS-1:0] s, input logic b);
      logic fb;
      fb = s[TAP_FB] ^ s[TAP_A] ^ (s[TAP_B] & s[TAP_C]) ^ (s[TAP_D] | s[TAP_E]) ^ b;
      return {s[STATE_BITS-2:0], fb};
   endfunction

   // Output function on separate taps, so state bits are never shown directly
   function automatic logic pp_out(input logic [STATE_BITS-1:0] s);
      return s[OUT_A] ^ s[OUT_B] ^ (s[OUT_C] & s[OUT_D]) ^ s[OUT_E];
   endfunction

   function automatic logic in_band(input logic [OW-1:0] v, input logic [OW-1:0] lo, input logic [OW-1:0] hi);
      return (v >= lo) && (v <= hi);
   endfunction

   gen_state_e            state_reg, state_next;
   logic [RW-1:0]         run_reg, run_next;
   logic                  last_reg, last_next;
   logic                  have_last_reg, have_last_next;
   logic [WW-1:0]         win_reg, win_next;
   logic [OW-1:0]         ones_reg, ones_next;
   logic                  pass_reg, pass_next;
   logic                  fine_reg, fine_next;
   logic [2:0]            grp_reg, grp_next;
   logic                  acc_reg, acc_next;
   logic [STATE_BITS-1:0] pp_reg, pp_next;
   logic [SW-1:0]         seed_cnt_reg, seed_cnt_next;
   logic                  seeded_reg, seeded_next;
   logic [CREDIT_W-1:0]   credit_reg, credit_next;
   logic [WORD_W-1:0]     word_reg, word_next;
   logic [4:0]            bit_cnt_reg, bit_cnt_next;
   logic                  wide_reg, wide_next;
   logic                  pend_reg, pend_next;
   logic                  tfail_reg, tfail_next;
   logic                  sdef_reg, sdef_next;
   logic                  rel_reg, rel_next;
   logic                  raw_take;
   logic                  total_hit;
   logic                  stat_hit;
   logic                  comp_valid;
   logic                  comp_bit;
   logic                  transition;
   logic                  push;
   logic                  flush;
   logic                  fifo_ready;
   logic [OW-1:0]         ones_sum;

   assign o_total_fail  = tfail_reg;
   assign o_stat_defect = sdef_reg;
   assign o_released    = rel_reg;
   assign o_seeded      = seeded_reg;

   // Health tests, compression, post-processor and gating
   always_comb begin
      state_next     = state_reg;
      run_next       = run_reg;
      last_next      = last_reg;
      have_last_next = have_last_reg;
      win_next       = win_reg;
      ones_next      = ones_reg;
      pass_next      = pass_reg;
      fine_next      = fine_reg;
      grp_next       = grp_reg;
      acc_next       = acc_reg;
      pp_next        = pp_reg;
      seed_cnt_next  = seed_cnt_reg;
      seeded_next    = seeded_reg;
      credit_next    = credit_reg;
      word_next      = word_reg;
      bit_cnt_next   = bit_cnt_reg;
      wide_next      = wide_reg;
      pend_next      = pend_reg;
      total_hit      = 1'b0;
      stat_hit       = 1'b0;
      comp_valid     = 1'b0;
      comp_bit       = 1'b0;
      transition     = 1'b0;
      ones_sum       = ones_reg + OW'(i_raw_bit);
      raw_take       = i_raw_valid && (state_reg == ST_STARTUP || state_reg == ST_RUN); // R5

      if (raw_take) begin
         // Stuck source shows as a long run of equal bits
         transition     = have_last_reg && (i_raw_bit != last_reg);
         if (!have_last_reg || transition) begin
            run_next = RW'(1);
         end else if (run_reg != RUN_TOP) begin
            run_next = run_reg + 1'b1;
         end
         last_next      = i_raw_bit;
         have_last_next = 1'b1;
         total_hit      = (run_next == RUN_TOP); // R1
         // Monobit window test, first window is the start-up test
         if (win_reg == WIN_LAST) begin
            win_next  = '0;
            ones_next = '0;
            stat_hit  = !in_band(ones_sum, LO_C, HI_C); // R3
            if (!stat_hit) begin
               pass_next = 1'b1; // R4
            end
            fine_next = in_band(ones_sum, TLO_C, THI_C); // R9
         end else begin
            win_next  = win_reg + 1'b1;
            ones_next = ones_sum;
         end
         // Adaptive XOR compression, ratio from the estimator
         if (grp_reg == (fine_reg ? FINE_LAST : COARSE_LAST)) begin // R9
            comp_valid = 1'b1;
            comp_bit   = acc_reg ^ i_raw_bit;
            grp_next   = '0;
            acc_next   = 1'b0;
         end else begin
            grp_next   = grp_reg + 1'b1;
            acc_next   = acc_reg ^ i_raw_bit;
         end
      end

      // Input always absorbed; output steps only in cycles with no input
      if (comp_valid) begin
         pp_next = pp_step(pp_reg, comp_bit); // R7 R10
         if (!seeded_reg) begin
            seed_cnt_next = seed_cnt_reg + 1'b1;
            seeded_next   = (seed_cnt_reg == SEED_LAST); // R10
         end else if (credit_reg != CREDIT_TOP) begin
            credit_next = credit_reg + 1'b1; // R6
         end
      end else if (state_reg == ST_RUN && !pend_reg && credit_reg != '0) begin
         pp_next      = pp_step(pp_reg, 1'b0); // R7
         credit_next  = credit_reg - 1'b1; // R6
         word_next    = {word_reg[WORD_W-2:0], pp_out(pp_reg)}; // R7
         bit_cnt_next = bit_cnt_reg + 1'b1;
         if (bit_cnt_reg == '0) begin
            wide_next = i_word16; // Format fixed for the whole word
         end
         if (bit_cnt_reg == ((bit_cnt_reg == '0 ? i_word16 : wide_reg) ? W16_LAST : W8_LAST)) begin // R8
            pend_next    = 1'b1;
            bit_cnt_next = '0;
         end
      end

      // Finished word waits for a raw transition, so a failing run drops it
      push = pend_reg && transition && fifo_ready && (state_reg == ST_RUN) && !total_hit && !stat_hit; // R2
      if (push) begin
         pend_next = 1'b0;
      end

      // Sticky errors, set wins over the clearing start
      tfail_next = total_hit || (tfail_reg && !i_start); // R11
      sdef_next  = stat_hit || (sdef_reg && !i_start); // R11

      case (state_reg)
         ST_IDLE: begin
            if (i_start) begin
               state_next = ST_STARTUP;
            end
         end
         ST_STARTUP: begin
            if (total_hit || stat_hit) begin
               state_next = ST_FAIL; // R1 R3
            end else if (pass_reg && seeded_reg) begin
               state_next = ST_RUN; // R4
            end
         end
         ST_RUN: begin
            if (total_hit || stat_hit) begin
               state_next = ST_FAIL; // R2 R4
            end
         end
         ST_FAIL: begin
            state_next = ST_FAIL;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase

      // Restart clears test progress and reseeds; the state keeps its entropy
      if (i_start && !total_hit && !stat_hit) begin
         state_next     = ST_STARTUP;
         run_next       = '0;
         have_last_next = 1'b0;
         win_next       = '0;
         ones_next      = '0;
         pass_next      = 1'b0;
         fine_next      = 1'b0;
         grp_next       = '0;
         acc_next       = 1'b0;
         seed_cnt_next  = '0;
         seeded_next    = 1'b0;
         credit_next    = '0;
         bit_cnt_next   = '0;
         pend_next      = 1'b0;
      end
      if (state_next == ST_FAIL) begin
         pend_next = 1'b0; // R2
      end

      flush    = (state_next != ST_RUN); // R4 R12
      rel_next = (state_next == ST_RUN); // R12
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_reg     <= ST_IDLE;
         run_reg       <= '0;
         last_reg      <= 1'b0;
         have_last_reg <= 1'b0;
         win_reg       <= '0;
         ones_reg      <= '0;
         pass_reg      <= 1'b0;
         fine_reg      <= 1'b0;
         grp_reg       <= '0;
         acc_reg       <= 1'b0;
         pp_reg        <= '0;
         seed_cnt_reg  <= '0;
         seeded_reg    <= 1'b0;
         credit_reg    <= '0;
         word_reg      <= '0;
         bit_cnt_reg   <= '0;
         wide_reg      <= 1'b0;
         pend_reg      <= 1'b0;
         tfail_reg     <= 1'b0;
         sdef_reg      <= 1'b0;
         rel_reg       <= 1'b0;
      end else begin
         state_reg     <= state_next;
         run_reg       <= run_next;
         last_reg      <= last_next;
         have_last_reg <= have_last_next;
         win_reg       <= win_next;
         ones_reg      <= ones_next;
         pass_reg      <= pass_next;
         fine_reg      <= fine_next;
         grp_reg       <= grp_next;
         acc_reg       <= acc_next;
         pp_reg        <= pp_next;
         seed_cnt_reg  <= seed_cnt_next;
         seeded_reg    <= seeded_next;
         credit_reg    <= credit_next;
         word_reg      <= word_next;
         bit_cnt_reg   <= bit_cnt_next;
         wide_reg      <= wide_next;
         pend_reg      <= pend_next;
         tfail_reg     <= tfail_next;
         sdef_reg      <= sdef_next;
         rel_reg       <= rel_next;
      end
   end

   // Narrow words sit in the low byte, upper byte zero
   rng_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH_P)
   ) u_fifo (
      .i_mclk     (i_mclk),
      .i_resetn   (i_resetn),
      .i_flush    (flush),
      .i_wr_valid (push),
      .o_wr_ready (fifo_ready),
      .i_wr_data  (wide_reg ? word_reg : {8'h00, word_reg[NARROW_W-1:0]}), // R8
      .o_rd_valid (o_rd_valid), // R12
      .i_rd_ready (i_rd_ready),
      .o_rd_data  (o_rd_data)
   );
endmodule // hybrid_rng_health_gate
`default_nettype wire

// file: test/hybrid_rng_health_gate_properties.sv
// Concurrent checks on the ports of the hybrid generator's top module.
// Assumes i_mclk and active-low async reset i_resetn.
`timescale 1ns/1ns
`default_nettype none
module hybrid_rng_health_gate_properties
   import rng_pkg::*;
#(
   parameter int RUN_MAX_P = RUN_LIMIT
) (
   input wire logic              i_mclk,
   input wire logic              i_resetn,
   input wire logic              i_start,
   input wire logic              i_raw_valid,
   input wire logic              i_raw_bit,
   input wire logic              i_word16,
   input wire logic              i_rd_ready,
   input wire logic [WORD_W-1:0] o_rd_data,
   input wire logic              o_rd_valid,
   input wire logic              o_total_fail,
   input wire logic              o_stat_defect,
   input wire logic              o_released,
   input wire logic              o_seeded
);
   logic [7:0]  run_cnt_reg, run_cnt_next;
   logic        last_bit_reg, last_bit_next;
   logic [15:0] raw_cnt_reg, raw_cnt_next;

   // Run length and raw count since start
   always_comb begin
      run_cnt_next  = run_cnt_reg;
      last_bit_next = last_bit_reg;
      raw_cnt_next  = raw_cnt_reg;
      if (i_start) begin
         run_cnt_next = 8'h00;
         raw_cnt_next = 16'h0000;
      end else if (i_raw_valid) begin
         last_bit_next = i_raw_bit;
         run_cnt_next  = (i_raw_bit == last_bit_reg && run_cnt_reg != 8'h00 && run_cnt_reg != 8'hff) ?
                         run_cnt_reg + 8'h01 : 8'h01;
         if (raw_cnt_reg != 16'hffff) raw_cnt_next = raw_cnt_reg + 16'h0001;
      end
   end

   // Helper registers only
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         run_cnt_reg  <= 8'h00;
         last_bit_reg <= 1'b0;
         raw_cnt_reg  <= 16'h0000;
      end else begin
         run_cnt_reg  <= run_cnt_next;
         last_bit_reg <= last_bit_next;
         raw_cnt_reg  <= raw_cnt_next;
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);

   // Last bit of a failing run arrives while released
   sequence s_run_hit;
      o_released && !i_start && i_raw_valid && i_raw_bit == last_bit_reg && run_cnt_reg == RUN_MAX_P - 1;
   endsequence
   // Word held by consumer
   sequence s_word_stalled;
      o_rd_valid && !i_rd_ready;
   endsequence

   property p_run_fail;
      s_run_hit |=> o_total_fail && !o_released && !o_rd_valid;
   endproperty
   property p_fail_blocks;
      o_total_fail |-> !o_released && !o_rd_valid;
   endproperty
   property p_defect_blocks;
      o_stat_defect |-> !o_released && !o_rd_valid;
   endproperty
   property p_valid_gated;
      o_rd_valid |-> o_released;
   endproperty
   property p_release_cause;
      $rose(o_released) |-> o_seeded && !o_stat_defect && !o_total_fail;
   endproperty
   property p_seed_length;
      $rose(o_released) |-> raw_cnt_reg >= 16'(2 * SEED_BITS);
   endproperty
   property p_fail_sticky;
      o_total_fail && !i_start |=> o_total_fail;
   endproperty
   property p_defect_sticky;
      o_stat_defect && !i_start |=> o_stat_defect;
   endproperty
   property p_word_holds;
      s_word_stalled |=> (o_rd_valid && $stable(o_rd_data)) || !o_released;
   endproperty
   property p_start_clears;
      i_start && !i_raw_valid |=> !o_total_fail && !o_stat_defect && !o_released;
   endproperty

   a_run_fail:      assert property (p_run_fail)      else $error("run did not fail");
   a_fail_blocks:   assert property (p_fail_blocks)   else $error("open after fail");
   a_defect_blocks: assert property (p_defect_blocks) else $error("open after defect");
   a_valid_gated:   assert property (p_valid_gated)   else $error("word valid while gate closed");
   a_release_cause: assert property (p_release_cause) else $error("bad gate open");
   a_seed_length:   assert property (p_seed_length)   else $error("early gate open");
   a_fail_sticky:   assert property (p_fail_sticky)   else $error("failure flag dropped");
   a_defect_sticky: assert property (p_defect_sticky) else $error("defect flag dropped");
   a_word_holds:    assert property (p_word_holds)    else $error("stalled word changed");
   a_start_clears:  assert property (p_start_clears)  else $error("start did not clear flags");
   c_fail: cover property ($rose(o_total_fail));
endmodule // hybrid_rng_health_gate_properties

bind hybrid_rng_health_gate hybrid_rng_health_gate_properties #(
   .RUN_MAX_P(RUN_MAX_P)
) u_props (.*);
`default_nettype wire

// file: test/rng_consumer_model.sv
// Consumer standing in for the software that drains random words.
// Assumes the generator clock; ready moves just after an edge.
`timescale 1ns/1ns
`default_nettype none
module rng_consumer_model
   import rng_pkg::*;
(
   input  wire logic              i_mclk,
   input  wire logic              i_hold,
   input  wire logic              i_slow,
   input  wire logic              i_word16,
   input  wire logic              i_rd_valid,
   input  wire logic [WORD_W-1:0] i_rd_data,
   output var  logic              o_rd_ready,
   output var  int                o_words,
   output var  int                o_upper_bad
);
   logic phase = 1'b0;
   initial begin
      o_rd_ready  = 1'b0;
      o_words     = 0;
      o_upper_bad = 0;
   end
   // Take a word where valid meets ready; narrow words must leave the top byte clear
   always @(posedge i_mclk) begin
      if (i_rd_valid && o_rd_ready) begin
         o_words <= o_words + 1;
         if (!i_word16 && i_rd_data[15:8] !== 8'h00) o_upper_bad <= o_upper_bad + 1;
      end
      phase <= !phase;
      o_rd_ready <= #1 !i_hold && (!i_slow || phase);
   end
endmodule // rng_consumer_model
`default_nettype wire

// file: test/hybrid_rng_health_gate_tb_top.sv
// Self-checking bench for the hybrid generator with short test parameters.
// Assumes the bound checker and the consumer model.
`timescale 1ns/1ns
`default_nettype none
module hybrid_rng_health_gate_tb_top;
   import rng_pkg::*;
   logic              i_mclk, i_resetn, i_start, i_raw_valid, i_raw_bit, i_word16, i_rd_ready;
   logic [WORD_W-1:0] o_rd_data;
   logic              o_rd_valid, o_total_fail, o_stat_defect, o_released, o_seeded;
   logic              hold, slow;
   int                words, upper_bad, base, got, n;
   int                error_cnt = 0, samples_checked = 0, raw_idx = 0, raw_since = 0, cyc = 0;

   // Short tests
   hybrid_rng_health_gate #(.RUN_MAX_P(8), .WIN_P(16), .LO_P(4), .HI_P(12)) dut (.*);
   rng_consumer_model u_consumer (.i_mclk(i_mclk), .i_hold(hold), .i_slow(slow), .i_word16(i_word16),
      .i_rd_valid(o_rd_valid), .i_rd_data(o_rd_data), .o_rd_ready(i_rd_ready), .o_words(words),
      .o_upper_bad(upper_bad));

   initial begin
      i_mclk = 1'b0;
      forever #25 i_mclk = ~i_mclk;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Pattern 0 alternates, 1 has one high bit in eight, 2 is stuck high
   task automatic feed(input int mode, input int cnt);
      repeat (cnt) begin
         @(posedge i_mclk);
         #2;
         i_raw_valid = 1'b1;
         i_raw_bit = (mode == 0) ? raw_idx[0] : (mode == 1) ? (raw_idx[2:0] == 3'd7) : 1'b1;
         raw_idx++;
         raw_since++;
      end
      @(posedge i_mclk);
      #2;
      i_raw_valid = 1'b0;
   endtask

   task automatic pulse_start();
      @(posedge i_mclk);
      #2;
      i_start = 1'b1;
      raw_since = 0;
      @(posedge i_mclk);
      #2;
      i_start = 1'b0;
   endtask

   task automatic t_idle();
      feed(0, 40);
      check("released", o_released, 0);
      check("seeded", o_seeded, 0);
      check("valid", o_rd_valid, 0);
      $display("test idle done");
   endtask

   task automatic t_start_defect();
      pulse_start();
      feed(1, 64);
      check("defect", o_stat_defect, 1);
      check("fail", o_total_fail, 0);
      check("released", o_released, 0);
      check("valid", o_rd_valid, 0);
      $display("test start defect done");
   endtask

   task automatic t_seed_run(input logic w16, input logic slw);
      i_word16 = w16;
      slow = slw;
      pulse_start();
      check("fail", o_total_fail, 0);
      check("defect", o_stat_defect, 0);
      n = 0;
      while (o_released !== 1'b1 && n < 4000) begin
         feed(0, 1);
         n++;
      end
      check("released", o_released, 1);
      check("seeded", o_seeded, 1);
      check("seed raw bits", raw_since >= 2 * SEED_BITS, 1);
      base = words;
      feed(0, 600);
      repeat (20) @(posedge i_mclk);
      #2;
      got = words - base;
      check("words out", got > 0, 1);
      check("upper byte", upper_bad, 0);
      check("rate bound", got * (w16 ? 16 : 8) <= raw_since / 2 - SEED_BITS, 1);
      check("defect", o_stat_defect, 0);
      $display("test seed and run done");
   endtask

   task automatic t_stall();
      hold = 1'b1;
      #60;
      base = words;
      feed(0, 800);
      check("stalled valid", o_rd_valid, 1);
      check("stalled count", words - base, 0);
      hold = 1'b0;
      repeat (40) @(posedge i_mclk);
      #2;
      got = words - base;
      check("fifo fill", got >= FIFO_DEPTH && got <= FIFO_DEPTH + 1, 1);
      $display("test stall done");
   endtask

   task automatic t_run_fail();
      feed(2, 8);
      check("fail", o_total_fail, 1);
      check("released", o_released, 0);
      check("valid", o_rd_valid, 0);
      base = words;
      feed(0, 100);
      check("words after fail", words - base, 0);
      check("fail held", o_total_fail, 1);
      $display("test run fail done");
   endtask

   task automatic t_run_defect();
      feed(1, 48);
      check("defect", o_stat_defect, 1);
      check("released", o_released, 0);
      check("valid", o_rd_valid, 0);
      $display("test run defect done");
   endtask

   // Cycle ceiling
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         $display("[ERR] timeout expected end seen hang");
         test_done();
      end
   end

   initial begin
      i_resetn = 1'b0;
      i_start = 1'b0;
      i_raw_valid = 1'b0;
      i_raw_bit = 1'b0;
      i_word16 = 1'b0;
      hold = 1'b0;
      slow = 1'b0;
      repeat (2) @(posedge i_mclk);
      #2;
      i_resetn = 1'b1;
      t_idle();
      t_start_defect();
      t_seed_run(1'b0, 1'b1);
      t_stall();
      t_run_fail();
      t_seed_run(1'b1, 1'b0);
      t_run_defect();
      test_done();
   end
endmodule // hybrid_rng_health_gate_tb_top
`default_nettype wire
